//--- pkg/lcrs_defines.svh
/*
  Constants of the common row scanner: stage count, level codes, reset values.
  Assumes it is included by bare name wherever these numbers are needed.
*/
`ifndef LCRS_DEFINES_SVH
`define LCRS_DEFINES_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define LCRS_STAGES       96

// ****************************************************************
// Drive level codes
// ****************************************************************
`define LCRS_LVL_VSS_CODE 2'h0
`define LCRS_LVL_V1_CODE  2'h1
`define LCRS_LVL_V4_CODE  2'h2
`define LCRS_LVL_V0_CODE  2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define LCRS_RST_BIT      1'h0
`define LCRS_RST_OE       1'h0

`endif

//--- pkg/lcrs_pkg.sv
/*
  Types of the common row scanner: drive level, scan state, pin drive pair.
  Assumes lcrs_defines.svh is on the include path.
*/
`include "lcrs_defines.svh"

package lcrs_pkg;

  // Four voltage levels a drive output can select
  typedef enum logic [1:0] {
    LCRS_LVL_VSS = `LCRS_LVL_VSS_CODE,
    LCRS_LVL_V1  = `LCRS_LVL_V1_CODE,
    LCRS_LVL_V4  = `LCRS_LVL_V4_CODE,
    LCRS_LVL_V0  = `LCRS_LVL_V0_CODE
  } lcrs_level_type;

  // Scan state: display off, waiting for first latch, running
  typedef enum logic [1:0] {
    LCRS_ST_OFF  = 2'b00,
    LCRS_ST_WAIT = 2'b01,
    LCRS_ST_RUN  = 2'b10
  } lcrs_state_type;

  // Output half of a two-way pin
  typedef struct packed {
    logic dout;
    logic oe;
  } lcrs_pin_drv_type;

endpackage : lcrs_pkg

//--- rtl/lcrs_fall_det.sv
/*
  Falling edge detector for a group of strobe inputs.
  Assumes inputs are synchronous to core_clk; pulses are combinational.
*/
module lcrs_fall_det #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk, // System clock
  input  wire logic             arst_n,   // Async reset, active low
  input  wire logic [WIDTH-1:0] level_in, // Strobe levels
  output logic      [WIDTH-1:0] fall      // One-cycle falling edge pulses
);

  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] prev_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("lcrs_fall_det: WIDTH must be at least 1");
  end

  // Next previous-level value
  always_comb begin
    prev_nxt = level_in;
  end

  // Previous-level register; idle-low after reset so no false edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // High then low marks a falling edge
  assign fall = prev_r & ~level_in;

endmodule : lcrs_fall_det

//--- rtl/lcrs_row_scanner.sv
/*
  Common (row) scanner of a multi-output LCD driver: a bidirectional shift
  register carries the frame marker, and each stage selects a drive level.
  Assumes all strobe and pin inputs are synchronous to core_clk and that the
  external timing controller drives the row shift clock as the mode needs.
*/
`include "lcrs_defines.svh"

// Overview of operation
// - Shift register advances one stage per falling edge of row shift clock.
// - Display-off low forces every drive output to ground level.
// - Display-off low clears every shift register stage.
// - After display-off release outputs sit at non-select until data captured.
// - After release, shift data captured at first falling latch pulse edge.
// - Output level chosen from frame AC signal and matching stage bit.
// - Each stage maps to one drive output choosing one of four levels.
// - Direction one: pin a is marker input, pin b is shift output.
// - Direction zero: pin b is marker input, pin a is shift output.
module lcrs_row_scanner #(
  parameter int STAGES = `LCRS_STAGES
) (
  input  wire logic                                core_clk,         // 250 MHz clock
  input  wire logic                                arst_n,           // Async reset
  input  wire logic                                row_shift_clock,  // Row shift strobe
  input  wire logic                                line_latch_pulse, // Line latch strobe
  input  wire logic                                display_off_n,    // Display off
  input  wire logic                                frame_ac_signal,  // Frame inversion
  input  wire logic                                scan_dir,         // Direction bit
  input  wire logic                                cascade_pin_a_in, // Pin a level
  input  wire logic                                cascade_pin_b_in, // Pin b level
  output lcrs_pkg::lcrs_pin_drv_type               cascade_pin_a_drv, // Pin a drive
  output lcrs_pkg::lcrs_pin_drv_type               cascade_pin_b_drv, // Pin b drive
  output lcrs_pkg::lcrs_level_type [STAGES-1:0]    drive_outputs     // Level per output
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (STAGES < 2) begin : g_chk
    $error("lcrs_row_scanner: STAGES must be at least 2");
  end

  // ****************************************************************
  // Level selection
  // ****************************************************************

  // Select level from stage bit and frame phase; non-select is V1 or V4
  function automatic lcrs_pkg::lcrs_level_type sel_level(input logic bit_v,
                                                         input logic fr_v);
    if (bit_v) begin
      sel_level = fr_v ? lcrs_pkg::LCRS_LVL_V0 : lcrs_pkg::LCRS_LVL_VSS;
    end else begin
      sel_level = fr_v ? lcrs_pkg::LCRS_LVL_V4 : lcrs_pkg::LCRS_LVL_V1;
    end
  endfunction : sel_level

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  logic [1:0] falls;
  logic       shift_fall;
  logic       latch_fall;

  lcrs_fall_det #(
    .WIDTH    (2)
  ) u_fall (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .level_in ({line_latch_pulse, row_shift_clock}),
    .fall     (falls)
  );

  // Split edge pulses; the row clock may be the latch pulse tied in monochrome
  assign shift_fall = falls[0];
  assign latch_fall = falls[1];

  // ****************************************************************
  // Scan state and shift register
  // ****************************************************************
  lcrs_pkg::lcrs_state_type state_r;
  lcrs_pkg::lcrs_state_type state_nxt;
  logic [STAGES-1:0]        sr_r;
  logic [STAGES-1:0]        sr_nxt;
  logic                     marker_in;

  // Input cascade pin chosen by direction
  assign marker_in = scan_dir ? cascade_pin_a_in : cascade_pin_b_in;

  // Next state and next shift register contents
  always_comb begin
    state_nxt = state_r;
    sr_nxt    = sr_r;
    case (state_r)
      lcrs_pkg::LCRS_ST_OFF: begin
        sr_nxt = '0;
        if (display_off_n) begin
          state_nxt = lcrs_pkg::LCRS_ST_WAIT;
        end
      end
      lcrs_pkg::LCRS_ST_WAIT: begin
        if (!display_off_n) begin
          sr_nxt    = '0;
          state_nxt = lcrs_pkg::LCRS_ST_OFF;
        end else if (latch_fall) begin
          sr_nxt    = {sr_r[STAGES-2:0], marker_in};
          state_nxt = lcrs_pkg::LCRS_ST_RUN;
        end
      end
      lcrs_pkg::LCRS_ST_RUN: begin
        if (!display_off_n) begin
          sr_nxt    = '0;
          state_nxt = lcrs_pkg::LCRS_ST_OFF;
        end else if (shift_fall) begin
          sr_nxt = {sr_r[STAGES-2:0], marker_in};
        end
      end
      default: begin
        sr_nxt    = '0;
        state_nxt = lcrs_pkg::LCRS_ST_OFF;
      end
    endcase
  end

  // State and shift register flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= lcrs_pkg::LCRS_ST_OFF;
      sr_r    <= '0;
    end else begin
      state_r <= state_nxt;
      sr_r    <= sr_nxt;
    end
  end

  // ****************************************************************
  // Drive outputs
  // ****************************************************************
  lcrs_pkg::lcrs_level_type [STAGES-1:0] drv_r;
  lcrs_pkg::lcrs_level_type [STAGES-1:0] drv_nxt;

  // Stage order follows direction; off forces ground, wait forces non-select
  always_comb begin
    for (int i = 0; i < STAGES; i++) begin
      if (!display_off_n || state_nxt == lcrs_pkg::LCRS_ST_OFF) begin
        drv_nxt[i] = lcrs_pkg::LCRS_LVL_VSS;
      end else if (state_nxt == lcrs_pkg::LCRS_ST_WAIT) begin
        drv_nxt[i] = sel_level(1'b0, frame_ac_signal);
      end else if (scan_dir) begin
        drv_nxt[i] = sel_level(sr_nxt[i], frame_ac_signal);
      end else begin
        drv_nxt[i] = sel_level(sr_nxt[STAGES-1-i], frame_ac_signal);
      end
    end
  end

  // Drive level flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        drv_r[i] <= lcrs_pkg::LCRS_LVL_VSS;
      end
    end else begin
      drv_r <= drv_nxt;
    end
  end

  assign drive_outputs = drv_r;

  // ****************************************************************
  // Cascade pins
  // ****************************************************************
  lcrs_pkg::lcrs_pin_drv_type pin_a_r;
  lcrs_pkg::lcrs_pin_drv_type pin_b_r;
  lcrs_pkg::lcrs_pin_drv_type pin_a_nxt;
  lcrs_pkg::lcrs_pin_drv_type pin_b_nxt;

  // Output pin carries last stage; input pin is released
  always_comb begin
    pin_a_nxt.dout = scan_dir ? `LCRS_RST_BIT : sr_nxt[STAGES-1];
    pin_a_nxt.oe   = ~scan_dir;
    pin_b_nxt.dout = scan_dir ? sr_nxt[STAGES-1] : `LCRS_RST_BIT;
    pin_b_nxt.oe   = scan_dir;
  end

  // Cascade pin flops; both pins released during reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_a_r <= '{dout: `LCRS_RST_BIT, oe: `LCRS_RST_OE};
      pin_b_r <= '{dout: `LCRS_RST_BIT, oe: `LCRS_RST_OE};
    end else begin
      pin_a_r <= pin_a_nxt;
      pin_b_r <= pin_b_nxt;
    end
  end

  assign cascade_pin_a_drv = pin_a_r;
  assign cascade_pin_b_drv = pin_b_r;

endmodule : lcrs_row_scanner

//--- tb/lcrs_ctrl_model.sv
/*
  Model of the timing controller that feeds the row scanner.
  Assumes gap is at least 3 so the two strobes never overlap in gray mode.
*/
module lcrs_ctrl_model (
  input  wire logic       core_clk, // Clock
  input  wire logic       mono,     // Row clock tied to latch
  input  wire logic       mk,       // Marker for the next line
  input  wire logic [3:0] gap,      // Line length minus one, in cycles
  output logic            lat  = 1'b0, // Line latch strobe, idle low
  output logic            rowc = 1'b0, // Row shift strobe, idle low
  output logic            inv  = 1'b0, // Frame inversion
  output logic            mkr  = 1'b0  // Frame start marker
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // One line: latch strobe and marker update, then the row strobe (with the latch strobe when mono)
  always @(posedge core_clk) begin
    cnt  <= (cnt == 0) ? int'(gap) : cnt - 1;
    lat  <= (cnt == 0);
    rowc <= mono ? (cnt == 0) : (cnt == 2);
    if (cnt == 0) begin
      mkr <= mk;
      inv <= inv ^ mk;
    end
  end
endmodule : lcrs_ctrl_model

//--- tb/lcrs_row_scanner_checker.sv
/*
  Assertions on the row scanner ports.
  Assumes the lcrs_pkg types; bound to every scanner instance.
*/
module lcrs_row_checker #(
  parameter int STAGES = 96
) (
  input wire logic                                core_clk,          // Clock
  input wire logic                                arst_n,            // Reset
  input wire logic                                row_shift_clock,   // Row strobe
  input wire logic                                display_off_n,     // Display off
  input wire logic                                frame_ac_signal,   // Inversion
  input wire logic                                scan_dir,          // Direction
  input wire lcrs_pkg::lcrs_pin_drv_type          cascade_pin_a_drv, // Pin a
  input wire lcrs_pkg::lcrs_pin_drv_type          cascade_pin_b_drv, // Pin b
  input wire lcrs_pkg::lcrs_level_type [STAGES-1:0] drive_outputs    // Levels
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // A level is non-select when its two code bits differ
  property p_off; !display_off_n |=> drive_outputs == '0; endproperty
  a_off: assert property (p_off) else $error("outputs not at ground");
  property p_clr;
    !display_off_n ##1 display_off_n |=>
      !cascade_pin_a_drv.dout && !cascade_pin_b_drv.dout;
  endproperty
  a_clr: assert property (p_clr) else $error("stages not cleared");
  property p_wait; !display_off_n ##1 display_off_n |=> ^drive_outputs[0]; endproperty
  a_wait: assert property (p_wait) else $error("select level after release");
  property p_inv; display_off_n |=> drive_outputs[0][1] == $past(frame_ac_signal); endproperty
  a_inv: assert property (p_inv) else $error("level ignores inversion");
  property p_shf;
    $fell(row_shift_clock) && scan_dir && $stable(scan_dir) && display_off_n &&
      $past(display_off_n) |=> ^drive_outputs[1] == ^$past(drive_outputs[0]);
  endproperty
  a_shf: assert property (p_shf) else $error("no shift up");
  property p_rev;
    $fell(row_shift_clock) && !scan_dir && $stable(scan_dir) && display_off_n &&
      $past(display_off_n) |=>
      ^drive_outputs[STAGES-2] == ^$past(drive_outputs[STAGES-1]);
  endproperty
  a_rev: assert property (p_rev) else $error("no shift down");
  property p_dir1; scan_dir |=> cascade_pin_b_drv.oe && !cascade_pin_a_drv.oe; endproperty
  a_dir1: assert property (p_dir1) else $error("pin roles wrong");
  property p_dir0; !scan_dir |=> cascade_pin_a_drv.oe && !cascade_pin_b_drv.oe; endproperty
  a_dir0: assert property (p_dir0) else $error("pin roles wrong");
  property p_chn;
    cascade_pin_b_drv.oe && $past(display_off_n) |->
      cascade_pin_b_drv.dout == !(^drive_outputs[STAGES-1]);
  endproperty
  a_chn: assert property (p_chn) else $error("chain out wrong");
  c_shf: cover property ($fell(row_shift_clock) && display_off_n);
  c_on: cover property ($rose(display_off_n));
  c_sel: cover property (display_off_n ##1 !(^drive_outputs[0]));
endmodule : lcrs_row_checker

bind lcrs_row_scanner lcrs_row_checker #(.STAGES(STAGES)) i_chk (.core_clk, .arst_n,
  .row_shift_clock, .display_off_n, .frame_ac_signal, .scan_dir, .cascade_pin_a_drv,
  .cascade_pin_b_drv, .drive_outputs);

//--- tb/tb.sv
/*
  Self-checking bench of the row scanner with a queue model of the stages.
  Assumes the controller model and the bound checker are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 8;
  logic core_clk = 0, arst_n = 0, dof_n = 0, dir = 1, mono = 1, mk = 0, tgl = 0;
  logic [3:0] gap = 4'h3;
  logic lat, rowc, inv, mkr, pa, pb;
  lcrs_pkg::lcrs_pin_drv_type da, db;
  lcrs_pkg::lcrs_level_type [S-1:0] dr;
  int error_cnt = 0, checks = 0, cyc = 0, st;
  bit mq[$];
  bit prow, plat, minv, mdir, mv;
  lcrs_ctrl_model i_ctrl (.core_clk, .mono, .mk, .gap, .lat, .rowc, .inv, .mkr);
  lcrs_row_scanner #(.STAGES(S)) i_dut (.core_clk, .arst_n, .row_shift_clock(rowc),
    .line_latch_pulse(lat), .display_off_n(dof_n), .frame_ac_signal(inv), .scan_dir(dir),
    .cascade_pin_a_in(pa), .cascade_pin_b_in(pb), .cascade_pin_a_drv(da),
    .cascade_pin_b_drv(db), .drive_outputs(dr));
  // Marker on the input pin; an undriven pin toggles
  assign pa = dir ? mkr : (da.oe ? da.dout : tgl);
  assign pb = dir ? (db.oe ? db.dout : tgl) : mkr;
  initial forever #2 core_clk = ~core_clk;
  // Reference model of state and stages
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mq = {};
      repeat (S) mq.push_back(1'b0);
      {st, prow, plat, mv} = 0;
    end else begin
      if (!dof_n) begin
        st = 0;
        foreach (mq[i]) mq[i] = 1'b0;
      end else if (st == 0) st = 1;
      else if ((st == 1 && plat && !lat) || (st == 2 && prow && !rowc)) begin
        mq.push_front(dir ? pa : pb);
        void'(mq.pop_back());
        st = 2;
      end
      {prow, plat, minv, mdir, mv} = {rowc, lat, inv, dir, 1'b1};
      cyc++;
      if (cyc == 20000) begin
        error_cnt++;
        report_and_stop();
      end
    end
  end
  // Compare every output with the model between edges
  always @(negedge core_clk) if (arst_n && mv) begin
    for (int i = 0; i < S; i++)
      cmp_lvl(dr[i], st ? {minv, ~(mq[mdir ? i : S-1-i] ^ minv)} : 2'h0);
    cmp_pin(mdir ? db : da, {mq[S-1], 1'b1});
    cmp_pin(mdir ? da : db, 2'h0);
  end
  task automatic cmp_lvl(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected level at %0t: %h not %h", $time, got, exp);
    end
  endtask : cmp_lvl
  task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected pin at %0t: %h not %h", $time, got, exp);
    end
  endtask : cmp_pin
  task automatic step();
    @(posedge core_clk);
    mk  <= ($urandom % 4) == 0;
    gap <= 4'(3 + $urandom % 13);
    tgl <= ~tgl;
  endtask : step
  // Off pulse of 1..4 cycles, then a long run, twice
  task automatic run_test(input bit m, input bit d);
    @(posedge core_clk);
    mono <= m;
    dir  <= d;
    repeat (2) begin
      repeat (1 + $urandom % 4) step();
      dof_n <= 1'b1;
      repeat (300) step();
      dof_n <= 1'b0;
    end
    $display("test mono %0d dir %0d done", m, d);
  endtask : run_test
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(32'ha15fdfca));
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 4; k++) run_test(k[0], k[1]);
    // Let the last display-off be seen by the compares
    repeat (4) @(posedge core_clk);
    report_and_stop();
  end
endmodule : tb
